/* srsync_pkg.sv */
package srsync_pkg;
  localparam int SRS_LANES = 8;
  localparam int SRS_ADDR_W = 16;
  // printed offsets are register indices; byte address is index times four
  localparam logic [13:0] IDX_UCC_CTRL = 14'h046F;
  localparam logic [13:0] IDX_SYMBOL_LOCK = 14'h0470;
  localparam logic [13:0] IDX_FRAME_LOCK = 14'h0471;
  localparam logic [13:0] IDX_CHECKSUM_OK = 14'h0472;
  localparam logic [13:0] IDX_INIT_ALIGN = 14'h0473;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0474;
  localparam logic [13:0] IDX_FRAME_SIZE = 14'h0476;
  localparam logic [13:0] IDX_LINK_TEST = 14'h0477;
  localparam logic [13:0] IDX_MF_COUNT = 14'h0478;
  localparam logic [13:0] IDX_IRQ_FLAG = 14'h047A;
  localparam logic [13:0] IDX_SYNC_MASK = 14'h047B;
  localparam logic [13:0] IDX_ERR_LIMIT = 14'h047C;
  // irq flag / mask bit positions
  localparam int IRQ_SYMBOL = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_CHECKSUM = 2;
  localparam int IRQ_INIT = 3;
  localparam int IRQ_UCC = 5;
  localparam logic [7:0] IRQ_IMPL = 8'h2F;
  // field positions
  localparam int STAT_IRQ_CLR_BIT = 7;
  localparam int TEST_MODE_BIT = 7;
  localparam int THR_EN_BIT = 3;
  localparam logic [7:0] LINK_TEST_WMASK = 8'h88;
  localparam logic [7:0] SYNC_MASK_WMASK = 8'hE0;
  localparam int SYNC_UCC_BIT = 5;
  localparam int UCC_IRQ_RST_BIT = 7;
  localparam int UCC_CNT_DIS_BIT = 6;
  localparam int UCC_CNT_RST_BIT = 5;
  // reset values
  localparam logic [7:0] FRAME_SIZE_RST = 8'h01;
  localparam logic [7:0] MF_COUNT_RST = 8'h01;
  localparam logic [7:0] ERR_LIMIT_RST = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [SRS_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [SRS_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } srs_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } srs_axil_rsp_t;

  typedef struct packed {
    logic [7:0] symbol_lock;
    logic [7:0] frame_lock;
    logic [7:0] checksum_ok;
    logic [7:0] initial_alignment_ok;
    logic [7:0] bad_control_err;
  } srs_lane_stat_t;

  typedef struct packed {
    logic [7:0] octets_per_frame;
    logic alignment_test_select;
    logic threshold_mask_en;
    logic [7:0] alignment_multiframes_div4;
  } srs_link_cfg_t;
endpackage : srsync_pkg

/* srsync_rx_status.sv */
// What this block does
// - per-lane symbol lock flags, eight bits, 1 means locked.
// - writing 1 to bit 7 of a lane status register clears its interrupt.
// - symbol lock, checksum, alignment failures land in summary flag bits 0, 2, 3.
// - any lane losing symbol lock raises a sync request to the transmitter.
// - live per-lane frame lock flags; frame loss restarts synchronisation.
// - per-lane checksum flag is 1 when last checksum was correct.
// - per-lane alignment flag; loss reported on the lane group's sync output.
// - octets per frame takes only 1, 2 or 4; resets to 1.
// - test select bit 7 makes the receiver take alignment frames continuously.
// - multiframe count is value times four; resets to 1; zero never stored.
// - lane select picks which lane the bad-control strobes act on.
// - masked summary failure on any lane pulls the low-active interrupt low.
// - masked error count reaching the limit raises a sync request.
`timescale 1ns/1ns
`default_nettype none
module srsync_rx_status #(
  parameter int LANES = srsync_pkg::SRS_LANES,
  parameter int CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire srsync_pkg::srs_axil_req_t axil_req_in,
  output srsync_pkg::srs_axil_rsp_t axil_rsp_out,
  input wire srsync_pkg::srs_lane_stat_t lane_stat_in,
  output srsync_pkg::srs_link_cfg_t link_cfg_out,
  output logic sync_request_out_a_out,
  output logic sync_request_out_b_out,
  output logic irq_n_out
);
  import srsync_pkg::*;

  if (LANES != SRS_LANES) begin : g_lanes_chk
    $error("lane count must match register width");
  end
  if (CNT_W != 8) begin : g_cnt_chk
    $error("error counter must be eight bits wide");
  end

  localparam int HALF = LANES / 2;

  function automatic logic [13:0] word_index(input logic [SRS_ADDR_W-1:0] addr);
    word_index = addr[SRS_ADDR_W-1:2];
  endfunction : word_index

  function automatic logic frame_size_ok(input logic [7:0] v);
    frame_size_ok = (v == 8'h01) || (v == 8'h02) || (v == 8'h04);
  endfunction : frame_size_ok

  // bus write channel holding
  logic aw_held_r, w_held_r;
  logic [SRS_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [13:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_lane_en;
  logic wr_hit;

  // registers
  logic [7:0] symbol_lock_r, frame_lock_r, checksum_ok_r, init_align_r;
  logic [7:0] irq_flag_r, irq_mask_r;
  logic [7:0] frame_size_r, link_test_r, mf_count_r, sync_mask_r, err_limit_r;
  logic [LANES-1:0] ucc_dis_r, ucc_hit_r;
  logic [CNT_W-1:0] ucc_cnt_r [LANES];
  logic [31:0] rd_data;
  logic rd_hit;

  assign wr_go = aw_held_r && w_held_r && !axil_rsp_out.bvalid;
  assign wr_idx = word_index(awaddr_r);
  assign wr_byte = wdata_r[7:0];
  assign wr_lane_en = wr_go && wstrb_r[0];

  always_comb begin
    wr_hit = 1'b1;
    if (wr_idx == IDX_UCC_CTRL) begin
      wr_hit = 1'b1;
    end else if (wr_idx >= IDX_SYMBOL_LOCK && wr_idx <= IDX_IRQ_MASK) begin
      wr_hit = 1'b1;
    end else if (wr_idx >= IDX_FRAME_SIZE && wr_idx <= IDX_MF_COUNT) begin
      wr_hit = 1'b1;
    end else if (wr_idx >= IDX_IRQ_FLAG && wr_idx <= IDX_ERR_LIMIT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write address / data accepted in either order
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (axil_req_in.awvalid && axil_rsp_out.awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= axil_req_in.awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (axil_req_in.wvalid && axil_rsp_out.wready) begin
        w_held_r <= 1'b1;
        wdata_r <= axil_req_in.wdata;
        wstrb_r <= axil_req_in.wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // ready is registered, so a channel is refused for the cycle after it is taken
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      axil_rsp_out.awready <= 1'b0;
      axil_rsp_out.wready <= 1'b0;
      axil_rsp_out.bvalid <= 1'b0;
      axil_rsp_out.bresp <= RESP_OKAY;
    end else begin
      axil_rsp_out.awready <= !aw_held_r && !(axil_req_in.awvalid && axil_rsp_out.awready)
                              && !axil_rsp_out.bvalid && !wr_go;
      axil_rsp_out.wready <= !w_held_r && !(axil_req_in.wvalid && axil_rsp_out.wready)
                             && !axil_rsp_out.bvalid && !wr_go;
      if (wr_go) begin
        axil_rsp_out.bvalid <= 1'b1;
        axil_rsp_out.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req_in.bready) begin
        axil_rsp_out.bvalid <= 1'b0;
      end
    end
  end

  // live lane status sampled each clock; reads never disturb it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      symbol_lock_r <= '0;
      frame_lock_r <= '0;
      checksum_ok_r <= '0;
      init_align_r <= '0;
    end else begin
      symbol_lock_r <= lane_stat_in.symbol_lock;
      frame_lock_r <= lane_stat_in.frame_lock;
      checksum_ok_r <= lane_stat_in.checksum_ok;
      init_align_r <= lane_stat_in.initial_alignment_ok;
    end
  end

  // failure events are falling edges of the registered lane flags; the count event is a rising edge of the per-lane limit hit
  logic [7:0] irq_set;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_SYMBOL] = |(symbol_lock_r & ~lane_stat_in.symbol_lock);
    irq_set[IRQ_FRAME] = |(frame_lock_r & ~lane_stat_in.frame_lock);
    irq_set[IRQ_CHECKSUM] = |(checksum_ok_r & ~lane_stat_in.checksum_ok);
    irq_set[IRQ_INIT] = |(init_align_r & ~lane_stat_in.initial_alignment_ok);
    irq_set[IRQ_UCC] = |(~ucc_hit_r & ucc_hit_nxt());
  end

  function automatic logic [LANES-1:0] ucc_hit_nxt();
    logic [LANES-1:0] h;
    h = '0;
    for (int i = 0; i < LANES; i++) begin
      h[i] = (ucc_cnt_r[i] >= err_limit_r);
    end
    return h;
  endfunction : ucc_hit_nxt

  logic [7:0] irq_clr;
  always_comb begin
    irq_clr = '0;
    if (wr_lane_en) begin
      if (wr_idx == IDX_IRQ_FLAG) begin
        irq_clr = wr_byte;
      end else if (wr_idx == IDX_SYMBOL_LOCK) begin
        irq_clr[IRQ_SYMBOL] = wr_byte[STAT_IRQ_CLR_BIT];
      end else if (wr_idx == IDX_FRAME_LOCK) begin
        irq_clr[IRQ_FRAME] = wr_byte[STAT_IRQ_CLR_BIT];
      end else if (wr_idx == IDX_CHECKSUM_OK) begin
        irq_clr[IRQ_CHECKSUM] = wr_byte[STAT_IRQ_CLR_BIT];
      end else if (wr_idx == IDX_INIT_ALIGN) begin
        irq_clr[IRQ_INIT] = wr_byte[STAT_IRQ_CLR_BIT];
      end else if (wr_idx == IDX_UCC_CTRL) begin
        irq_clr[IRQ_UCC] = wr_byte[UCC_IRQ_RST_BIT];
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_flag_r <= '0;
    end else begin
      irq_flag_r <= ((irq_flag_r & ~irq_clr) | irq_set) & IRQ_IMPL;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_n_out <= 1'b1;
    end else begin
      irq_n_out <= !(|(irq_flag_r & irq_mask_r));
    end
  end

  // configuration registers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_mask_r <= '0;
      frame_size_r <= FRAME_SIZE_RST;
      link_test_r <= '0;
      mf_count_r <= MF_COUNT_RST;
      sync_mask_r <= '0;
      err_limit_r <= ERR_LIMIT_RST;
    end else if (wr_lane_en) begin
      if (wr_idx == IDX_IRQ_MASK) begin
        irq_mask_r <= wr_byte & IRQ_IMPL;
      end else if (wr_idx == IDX_FRAME_SIZE) begin
        if (frame_size_ok(wr_byte)) begin
          frame_size_r <= wr_byte;
        end
      end else if (wr_idx == IDX_LINK_TEST) begin
        link_test_r <= wr_byte & LINK_TEST_WMASK;
      end else if (wr_idx == IDX_MF_COUNT) begin
        if (wr_byte != 8'h00) begin
          mf_count_r <= wr_byte;
        end
      end else if (wr_idx == IDX_SYNC_MASK) begin
        sync_mask_r <= wr_byte & SYNC_MASK_WMASK;
      end else if (wr_idx == IDX_ERR_LIMIT) begin
        err_limit_r <= wr_byte;
      end
    end
  end

  // bad-control counters, strobes address the lane in the same write
  logic ucc_strobe_dis, ucc_strobe_rst;
  logic [2:0] ucc_sel;
  assign ucc_strobe_dis = wr_lane_en && (wr_idx == IDX_UCC_CTRL) && wr_byte[UCC_CNT_DIS_BIT];
  assign ucc_strobe_rst = wr_lane_en && (wr_idx == IDX_UCC_CTRL) && wr_byte[UCC_CNT_RST_BIT];
  assign ucc_sel = wr_byte[2:0];

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < LANES; i++) begin
        ucc_cnt_r[i] <= '0;
      end
      ucc_dis_r <= '0;
      ucc_hit_r <= '0;
    end else begin
      ucc_hit_r <= ucc_hit_nxt();
      for (int i = 0; i < LANES; i++) begin
        if (ucc_strobe_rst && ucc_sel == 3'(i)) begin
          ucc_cnt_r[i] <= '0;
          ucc_dis_r[i] <= 1'b0;
        end else begin
          if (ucc_strobe_dis && ucc_sel == 3'(i)) begin
            ucc_dis_r[i] <= 1'b1;
          end
          // saturate so a long burst cannot wrap below the limit
          if (lane_stat_in.bad_control_err[i] && !ucc_dis_r[i]
              && ucc_cnt_r[i] != {CNT_W{1'b1}}) begin
            ucc_cnt_r[i] <= ucc_cnt_r[i] + 1'b1;
          end
        end
      end
    end
  end

  // sync requests: lanes split over two outputs by lower and upper half
  logic [LANES-1:0] lane_req;
  logic ucc_sync_en;
  assign ucc_sync_en = sync_mask_r[SYNC_UCC_BIT];
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      lane_req[i] = !lane_stat_in.symbol_lock[i]
                    || !lane_stat_in.frame_lock[i]
                    || !lane_stat_in.initial_alignment_ok[i]
                    || (ucc_sync_en && ucc_hit_r[i]);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_request_out_a_out <= 1'b0;
      sync_request_out_b_out <= 1'b0;
    end else begin
      sync_request_out_a_out <= |lane_req[HALF-1:0];
      sync_request_out_b_out <= |lane_req[LANES-1:HALF];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_cfg_out <= '0;
    end else begin
      link_cfg_out.octets_per_frame <= frame_size_r;
      link_cfg_out.alignment_test_select <= link_test_r[TEST_MODE_BIT];
      link_cfg_out.threshold_mask_en <= link_test_r[THR_EN_BIT];
      link_cfg_out.alignment_multiframes_div4 <= mf_count_r;
    end
  end

  // read path
  logic [13:0] rd_idx;
  assign rd_idx = word_index(axil_req_in.araddr);
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    if (rd_idx == IDX_UCC_CTRL) begin
      rd_data[7:0] = ucc_hit_r;
    end else if (rd_idx == IDX_SYMBOL_LOCK) begin
      rd_data[7:0] = symbol_lock_r;
    end else if (rd_idx == IDX_FRAME_LOCK) begin
      rd_data[7:0] = frame_lock_r;
    end else if (rd_idx == IDX_CHECKSUM_OK) begin
      rd_data[7:0] = checksum_ok_r;
    end else if (rd_idx == IDX_INIT_ALIGN) begin
      rd_data[7:0] = init_align_r;
    end else if (rd_idx == IDX_IRQ_MASK) begin
      rd_data[7:0] = irq_mask_r;
    end else if (rd_idx == IDX_FRAME_SIZE) begin
      rd_data[7:0] = frame_size_r;
    end else if (rd_idx == IDX_LINK_TEST) begin
      rd_data[7:0] = link_test_r;
    end else if (rd_idx == IDX_MF_COUNT) begin
      rd_data[7:0] = mf_count_r;
    end else if (rd_idx == IDX_IRQ_FLAG) begin
      rd_data[7:0] = irq_flag_r;
    end else if (rd_idx == IDX_SYNC_MASK) begin
      rd_data[7:0] = sync_mask_r;
    end else if (rd_idx == IDX_ERR_LIMIT) begin
      rd_data[7:0] = err_limit_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      axil_rsp_out.arready <= 1'b0;
      axil_rsp_out.rvalid <= 1'b0;
      axil_rsp_out.rdata <= '0;
      axil_rsp_out.rresp <= RESP_OKAY;
    end else begin
      axil_rsp_out.arready <= !axil_rsp_out.rvalid
                              && !(axil_req_in.arvalid && axil_rsp_out.arready);
      if (axil_req_in.arvalid && axil_rsp_out.arready) begin
        axil_rsp_out.rvalid <= 1'b1;
        axil_rsp_out.rdata <= rd_data;
        axil_rsp_out.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req_in.rready) begin
        axil_rsp_out.rvalid <= 1'b0;
      end
    end
  end
endmodule : srsync_rx_status
`default_nettype wire

/* srsync_rx_status_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module srsync_rx_status_chk #(
  parameter int LANES = srsync_pkg::SRS_LANES,
  parameter int CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire srsync_pkg::srs_axil_req_t axil_req_in,
  input wire srsync_pkg::srs_axil_rsp_t axil_rsp_out,
  input wire srsync_pkg::srs_lane_stat_t lane_stat_in,
  input wire srsync_pkg::srs_link_cfg_t link_cfg_out,
  input wire logic sync_request_out_a_out,
  input wire logic sync_request_out_b_out,
  input wire logic irq_n_out
);
  import srsync_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic aw_hs = axil_req_in.awvalid && axil_rsp_out.awready;
  wire logic w_hs = axil_req_in.wvalid && axil_rsp_out.wready;
  wire logic ar_hs = axil_req_in.arvalid && axil_rsp_out.arready;
  // first edge after release still sees reset-time inputs
  a_sync_low_lanes: assert property (
    $past(reset_n_in) && !$past(&lane_stat_in.symbol_lock[3:0]) |-> sync_request_out_a_out)
    else $error("sync a not raised");
  a_sync_high_lanes: assert property (
    $past(reset_n_in) && !$past(&lane_stat_in.symbol_lock[7:4]) |-> sync_request_out_b_out)
    else $error("sync b not raised");
  a_write_answer: assert property (aw_hs && w_hs |-> ##[2:3] axil_rsp_out.bvalid)
    else $error("write response late");
  a_aw_refused: assert property (aw_hs |=> !axil_rsp_out.awready)
    else $error("awready after handshake");
  a_read_answer: assert property (ar_hs |-> ##[1:2] axil_rsp_out.rvalid)
    else $error("read response late");
  a_bresp_held: assert property (
    axil_rsp_out.bvalid && !axil_req_in.bready |=> axil_rsp_out.bvalid && $stable(axil_rsp_out.bresp))
    else $error("bresp dropped");
  a_rdata_held: assert property (
    axil_rsp_out.rvalid && !axil_req_in.rready |=> axil_rsp_out.rvalid && $stable(axil_rsp_out.rdata))
    else $error("rdata dropped");
  a_octets_legal: assert property (
    $past(reset_n_in) |-> link_cfg_out.octets_per_frame inside {8'h01, 8'h02, 8'h04})
    else $error("octets per frame illegal");
  c_write: cover property (aw_hs && w_hs);
  c_slverr: cover property (axil_rsp_out.rvalid && axil_rsp_out.rresp == RESP_SLVERR);
  c_irq: cover property (!irq_n_out);
  c_sync_b: cover property ($rose(sync_request_out_b_out));
endmodule : srsync_rx_status_chk
bind srsync_rx_status srsync_rx_status_chk #(.LANES(LANES), .CNT_W(CNT_W)) srsync_rx_status_chk_i (
  .clk_in, .reset_n_in, .axil_req_in, .axil_rsp_out, .lane_stat_in, .link_cfg_out,
  .sync_request_out_a_out, .sync_request_out_b_out, .irq_n_out);
`default_nettype wire

/* srsync_rx_status_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module srsync_rx_status_tb;
  import srsync_pkg::*;
  logic clk;
  logic rst_n;
  srs_axil_req_t req;
  srs_axil_rsp_t rsp;
  srs_lane_stat_t want;
  srs_lane_stat_t stat;
  srs_link_cfg_t cfg;
  logic sync_a;
  logic sync_b;
  logic irq_n;
  logic [31:0] d;
  logic [1:0] r;
  int n_mismatch = 0;
  int n_tests = 0;

  srsync_tx_model srsync_tx_model_i (.clk_in(clk), .reset_n_in(rst_n), .want_in(want),
    .lane_stat_out(stat));
  srsync_rx_status srsync_rx_status_i (.clk_in(clk), .reset_n_in(rst_n), .axil_req_in(req),
    .axil_rsp_out(rsp), .lane_stat_in(stat), .link_cfg_out(cfg),
    .sync_request_out_a_out(sync_a), .sync_request_out_b_out(sync_b), .irq_n_out(irq_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : ck

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    req.awaddr <= {idx, 2'h0};
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && rsp.awready) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w_ok && rsp.wready) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    // ready raised late so a held response is seen
    while (!rsp.bvalid) @(posedge clk);
    req.bready <= 1'b1;
    @(posedge clk);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [13:0] idx);
    req.araddr <= {idx, 2'h0};
    req.arvalid <= 1'b1;
    @(posedge clk);
    while (!rsp.arready) @(posedge clk);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk);
    req.rready <= 1'b1;
    @(posedge clk);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [13:0] idx, input logic [7:0] exp);
    rd(idx);
    ck($sformatf("reg %h", idx), d, {24'h0, exp});
  endtask : rc

  task automatic wrc(input logic [13:0] idx, input logic [7:0] v, input logic [7:0] exp);
    wr(idx, v);
    rc(idx, exp);
  endtask : wrc

  task automatic set_lane(input int f, input logic [7:0] v);
    case (f)
      0: want.symbol_lock <= v;
      1: want.frame_lock <= v;
      2: want.checksum_ok <= v;
      default: want.initial_alignment_ok <= v;
    endcase
  endtask : set_lane

  task automatic pulse(input logic [7:0] lanes);
    want.bad_control_err <= lanes;
    @(posedge clk);
    want.bad_control_err <= 8'h00;
    // model, counter, hit register and sync output each add one edge
    repeat (4) @(posedge clk);
  endtask : pulse

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    req = '0;
    want = '0;
    want.symbol_lock = 8'hFF;
    want.frame_lock = 8'hFF;
    want.checksum_ok = 8'hFF;
    want.initial_alignment_ok = 8'hFF;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ck("octets", cfg.octets_per_frame, 8'h01);
    ck("mf count", cfg.alignment_multiframes_div4, 8'h01);
    ck("sync a", sync_a, 1'b0);
    rc(IDX_FRAME_SIZE, 8'h01);
    rc(IDX_MF_COUNT, 8'h01);
    rc(IDX_LINK_TEST, 8'h00);
    wrc(IDX_FRAME_SIZE, 8'h02, 8'h02);
    wrc(IDX_FRAME_SIZE, 8'h03, 8'h02);
    wrc(IDX_FRAME_SIZE, 8'h04, 8'h04);
    wrc(IDX_MF_COUNT, 8'h00, 8'h01);
    wrc(IDX_MF_COUNT, 8'h05, 8'h05);
    wrc(IDX_LINK_TEST, 8'hFF, 8'h88);
    ck("octets", cfg.octets_per_frame, 8'h04);
    ck("mf count", cfg.alignment_multiframes_div4, 8'h05);
    ck("test select", cfg.alignment_test_select, 1'b1);
    ck("thr en", cfg.threshold_mask_en, 1'b1);
    wr(14'h0475, 8'h11);
    ck("bresp", r, RESP_SLVERR);
    rd(14'h0475);
    ck("rresp", r, RESP_SLVERR);
    // bad-control counting: limit 2, errors on lane 5 raise sync b
    wrc(IDX_ERR_LIMIT, 8'h02, 8'h02);
    wr(IDX_SYNC_MASK, 8'h20);
    pulse(8'h20);
    rc(IDX_UCC_CTRL, 8'h00);
    pulse(8'h20);
    ck("sync b", sync_b, 1'b1);
    rc(IDX_UCC_CTRL, 8'h20);
    rc(IDX_IRQ_FLAG, 8'h20);
    ck("irq_n", irq_n, 1'b1);
    wr(IDX_UCC_CTRL, 8'h44);
    pulse(8'h10);
    pulse(8'h10);
    rc(IDX_UCC_CTRL, 8'h20);
    wr(IDX_UCC_CTRL, 8'hA5);
    rc(IDX_UCC_CTRL, 8'h00);
    rc(IDX_IRQ_FLAG, 8'h00);
    ck("sync b", sync_b, 1'b0);
    wr(IDX_IRQ_MASK, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      set_lane(i, 8'hFD);
      repeat (4) @(posedge clk);
      ck("irq_n", irq_n, 1'b0);
      rc(IDX_SYMBOL_LOCK + 14'(i), 8'hFD);
      rc(IDX_IRQ_FLAG, 8'h01 << i);
      set_lane(i, 8'hFF);
      wr(IDX_SYMBOL_LOCK + 14'(i), 8'h80);
      rc(IDX_IRQ_FLAG, 8'h00);
      ck("irq_n", irq_n, 1'b1);
    end
    set_lane(0, 8'hBF);
    repeat (4) @(posedge clk);
    ck("sync b", sync_b, 1'b1);
    ck("sync a", sync_a, 1'b0);
    report_and_stop();
  end
endmodule : srsync_rx_status_tb
`default_nettype wire

/* srsync_tx_model.sv */
`timescale 1ns/1ns
`default_nettype none
module srsync_tx_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire srsync_pkg::srs_lane_stat_t want_in,
  output srsync_pkg::srs_lane_stat_t lane_stat_out
);
  import srsync_pkg::*;
  // lanes report lost during reset, as an unlocked link would
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lane_stat_out <= '0;
    end else begin
      lane_stat_out <= want_in;
    end
  end
endmodule : srsync_tx_model
`default_nettype wire
